// ==== pkg/epw_defs.svh ====
`ifndef EPW_DEFS_SVH
`define EPW_DEFS_SVH

// Clock rate in MHz
`define EPW_CLK_NS          100
`define EPW_CLK_PERIOD_NS   10
// Strobe timing, figures in ns
`define EPW_T_WP_NS         100
`define EPW_T_WPH_NS        50
`define EPW_T_AS_NS         10
`define EPW_T_AH_NS         50
`define EPW_T_OE_NS         150
`define EPW_T_OEHP_NS       150
// Least times round up to whole cycles, then one more cycle is added
`define EPW_CYC(ns)         ((((ns) + `EPW_CLK_PERIOD_NS - 1) / `EPW_CLK_PERIOD_NS) + 1)
// Byte load window in us, host keeps a margin of one third
`define EPW_BLC_US          150
`define EPW_BLC_SAFE_CYC    ((`EPW_BLC_US * 1000 / `EPW_CLK_PERIOD_NS) * 2 / 3)
// Longest write period in ms, used as poll timeout
`define EPW_WC_MS           10
`define EPW_WC_CYC          (`EPW_WC_MS * 1000000 / `EPW_CLK_PERIOD_NS)
// Page and data shape
`define EPW_PAGE_MAX        128
`define EPW_ADDR_W          19
`define EPW_DATA_W          8
`define EPW_PAGE_LSB        7
`define EPW_TOGGLE_BIT      6
// Protection command addresses and bytes
`define EPW_CMD_ADDR_A      19'h05555
`define EPW_CMD_ADDR_B      19'h02AAA
`define EPW_CMD_BYTE_A      8'hAA
`define EPW_CMD_BYTE_B      8'h55
`define EPW_CMD_PROT_ON     8'hA0
`define EPW_CMD_PROT_OFF_1  8'h80
`define EPW_CMD_PROT_OFF_2  8'h20
// Fixed command address width and sequence lengths
`define EPW_CMD_ADDR_W      15
`define EPW_CMD_LEN_ON      3
`define EPW_CMD_LEN_OFF     6

`endif

// ==== pkg/epw_pkg.sv ====
package epw_pkg;

	typedef enum logic [1:0] {
		EPW_OP_PLAIN    = 2'b00,
		EPW_OP_PROT_ON  = 2'b01,
		EPW_OP_PROT_OFF = 2'b10,
		EPW_OP_READ     = 2'b11
	} epw_op_e;

	typedef enum logic [3:0] {
		EPW_ST_IDLE   = 4'b0000,
		EPW_ST_CMD    = 4'b0001,
		EPW_ST_NEXT   = 4'b0010,
		EPW_ST_DATA   = 4'b0011,
		EPW_ST_POLL   = 4'b0100,
		EPW_ST_READ   = 4'b0101,
		EPW_ST_DONE   = 4'b0110
	} epw_state_e;

	typedef enum logic [1:0] {
		EPW_CYC_IDLE  = 2'b00,
		EPW_CYC_SETUP = 2'b01,
		EPW_CYC_ACT   = 2'b10,
		EPW_CYC_HOLD  = 2'b11
	} epw_cyc_e;

endpackage

// ==== rtl/epw_strobe.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "epw_defs.svh"

module epw_strobe
	import epw_pkg::*;
(
	// Clock and reset
	input  wire logic                    ref_clk_i,
	input  wire logic                    rst_n_i,
	// Request
	input  wire logic                    start_i,
	input  wire logic                    is_read_i,
	input  wire logic [`EPW_ADDR_W-1:0]  addr_i,
	input  wire logic [`EPW_DATA_W-1:0]  wdata_i,
	output logic                         done_o,
	output logic [`EPW_DATA_W-1:0]       rdata_o,
	// Pins
	output logic                         ce_n_o,
	output logic                         oe_n_o,
	output logic                         we_n_o,
	output logic [`EPW_ADDR_W-1:0]       addr_o,
	output logic [`EPW_DATA_W-1:0]       dq_o,
	output logic                         dq_oe_o,
	input  wire logic [`EPW_DATA_W-1:0]  dq_i
);

	localparam logic [7:0] SETUP_CYC = 8'(`EPW_CYC(`EPW_T_AS_NS));
	localparam logic [7:0] WP_CYC    = 8'(`EPW_CYC(`EPW_T_WP_NS));
	localparam logic [7:0] RD_CYC    = 8'(`EPW_CYC(`EPW_T_OE_NS));
	localparam logic [7:0] HOLD_CYC  = 8'(`EPW_CYC(`EPW_T_OEHP_NS));

	epw_cyc_e                   st_q;
	logic [7:0]                 cnt_q;
	logic                       rd_q;
	logic [`EPW_DATA_W-1:0]     dq_s1_q;
	logic [`EPW_DATA_W-1:0]     dq_s2_q;

	wire cnt_zero = (cnt_q == 8'h00);

	// ---------------------------------------------------------------
	// Data pin synchroniser, read data is sampled before release
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dq_s1_q <= 8'h00;
			dq_s2_q <= 8'h00;
		end else begin
			dq_s1_q <= dq_i;
			dq_s2_q <= dq_s1_q;
		end
	end

	// ---------------------------------------------------------------
	// One strobe cycle: setup, active, hold
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q    <= EPW_CYC_IDLE;
			cnt_q   <= 8'h00;
			rd_q    <= 1'b0;
			done_o  <= 1'b0;
			rdata_o <= 8'h00;
			ce_n_o  <= 1'b1;
			oe_n_o  <= 1'b1;
			we_n_o  <= 1'b1;
			addr_o  <= '0;
			dq_o    <= 8'h00;
			dq_oe_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (!cnt_zero) cnt_q <= cnt_q - 8'h01;
			case (st_q)
				EPW_CYC_IDLE: begin
					if (start_i) begin
						// Address settles before OE or WE falls, chip select falls with it
						rd_q    <= is_read_i;
						addr_o  <= addr_i;
						dq_o    <= wdata_i;
						dq_oe_o <= !is_read_i;
						ce_n_o  <= 1'b0;
						cnt_q   <= SETUP_CYC;
						st_q    <= EPW_CYC_SETUP;
					end
				end
				EPW_CYC_SETUP: begin
					if (cnt_zero) begin
						oe_n_o <= !rd_q;
						we_n_o <= rd_q;
						cnt_q  <= rd_q ? RD_CYC : WP_CYC;
						st_q   <= EPW_CYC_ACT;
					end
				end
				EPW_CYC_ACT: begin
					if (cnt_zero) begin
						if (rd_q) rdata_o <= dq_s2_q;
						oe_n_o <= 1'b1;
						we_n_o <= 1'b1;
						cnt_q  <= HOLD_CYC;
						st_q   <= EPW_CYC_HOLD;
					end
				end
				EPW_CYC_HOLD: begin
					// Bank select and address stay until chip select rises
					if (cnt_zero) begin
						ce_n_o  <= 1'b1;
						dq_oe_o <= 1'b0;
						done_o  <= 1'b1;
						st_q    <= EPW_CYC_IDLE;
					end
				end
				default: st_q <= EPW_CYC_IDLE;
			endcase
		end
	end

endmodule

`default_nettype wire

// ==== rtl/epw_host.sv ====
// What this block does
// - Read: CE, OE low, WE high; write: CE, WE low, OE high.
// - A page carries one to 128 bytes loaded one after another.
// - Page address bits stay the same for every byte of the page.
// - First three command bytes use the fixed command addresses on the low 15 lines.
// - Bank select lines stay stable while write or chip select is low.
// - Each next byte starts inside the byte load window.
// - Polling keeps one constant address throughout.
// - Command bytes go on data lines with line seven most significant.
`timescale 1ns/1ps
`default_nettype none
`include "epw_defs.svh"

module epw_host
	import epw_pkg::*;
#(
	parameter int unsigned BLC_SAFE_CYC = `EPW_BLC_SAFE_CYC,
	parameter int unsigned WC_CYC       = `EPW_WC_CYC
)
(
	// Clock and reset
	input  wire logic                    ref_clk_i,
	input  wire logic                    rst_n_i,
	// Command port
	input  wire logic                    req_i,
	input  wire epw_op_e                 op_i,
	input  wire logic [`EPW_ADDR_W-1:0]  addr_i,
	input  wire logic [7:0]              count_i,
	output logic                         busy_o,
	output logic                         done_o,
	output logic                         timeout_o,
	output logic [`EPW_DATA_W-1:0]       rdata_o,
	// Write data stream, one byte per accepted beat
	input  wire logic                    wvalid_i,
	input  wire logic [`EPW_DATA_W-1:0]  wdata_i,
	output logic                         wready_o,
	// Device pins
	output logic                         ce_n_o,
	output logic                         oe_n_o,
	output logic                         we_n_o,
	output logic [`EPW_ADDR_W-1:0]       addr_o,
	output logic [`EPW_DATA_W-1:0]       dq_o,
	output logic                         dq_oe_o,
	input  wire logic [`EPW_DATA_W-1:0]  dq_i
);

	epw_state_e                 st_q;
	epw_op_e                    op_q;
	logic [`EPW_ADDR_W-1:0]     base_q;
	logic [7:0]                 left_q;
	logic [7:0]                 offs_q;
	logic [2:0]                 cmd_idx_q;
	logic [31:0]                gap_q;
	logic [31:0]                wc_q;
	logic                       tog_q;
	logic                       tog_vld_q;
	logic                       cyc_start_q;
	logic                       cyc_read_q;
	logic [`EPW_ADDR_W-1:0]     cyc_addr_q;
	logic [`EPW_DATA_W-1:0]     cyc_data_q;
	logic                       cyc_done;
	logic [`EPW_DATA_W-1:0]     cyc_rdata;

	// ---------------------------------------------------------------
	// Command sequence tables
	// ---------------------------------------------------------------
	wire [2:0] cmd_len = (op_q == EPW_OP_PROT_OFF) ?
		3'(`EPW_CMD_LEN_OFF) : 3'(`EPW_CMD_LEN_ON);
	wire       cmd_lo  = (cmd_idx_q == 3'h1) || (cmd_idx_q == 3'h4);
	wire       cmd_hi  = (cmd_idx_q == 3'h0) || (cmd_idx_q == 3'h3);
	wire [`EPW_ADDR_W-1:0] cmd_fix = cmd_lo ? `EPW_CMD_ADDR_B : `EPW_CMD_ADDR_A;
	// Upper lines follow the target page, else the commands reach another bank
	wire [`EPW_ADDR_W-1:0] cmd_addr =
		{base_q[`EPW_ADDR_W-1:`EPW_CMD_ADDR_W], cmd_fix[`EPW_CMD_ADDR_W-1:0]};
	wire [`EPW_DATA_W-1:0] cmd_last = (op_q == EPW_OP_PROT_OFF) ?
		`EPW_CMD_PROT_OFF_2 : `EPW_CMD_PROT_ON;
	wire [`EPW_DATA_W-1:0] cmd_byte =
		cmd_hi ? `EPW_CMD_BYTE_A :
		cmd_lo ? `EPW_CMD_BYTE_B :
		(cmd_idx_q == 3'h2 && op_q == EPW_OP_PROT_OFF) ? `EPW_CMD_PROT_OFF_1 :
		cmd_last;

	// Page bits come from the base, only the low seven bits advance
	wire [`EPW_ADDR_W-1:0] data_addr =
		{base_q[`EPW_ADDR_W-1:`EPW_PAGE_LSB], offs_q[`EPW_PAGE_LSB-1:0]};
	wire [7:0] page_max = 8'(`EPW_PAGE_MAX);
	// Count 0 means a full page, larger is clipped
	wire [7:0] page_cnt = (count_i == 8'h00 || count_i > page_max) ? page_max : count_i;
	wire gap_late  = (gap_q >= BLC_SAFE_CYC);
	wire tog_now   = cyc_rdata[`EPW_TOGGLE_BIT];
	wire tog_same  = tog_vld_q && (tog_now == tog_q);
	wire wc_over   = (wc_q >= WC_CYC);
	wire take_byte = (st_q == EPW_ST_NEXT) && wvalid_i && !gap_late;

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q        <= EPW_ST_IDLE;
			op_q        <= EPW_OP_PLAIN;
			base_q      <= '0;
			left_q      <= 8'h00;
			offs_q      <= 8'h00;
			cmd_idx_q   <= 3'd0;
			gap_q       <= 32'd0;
			wc_q        <= 32'd0;
			tog_q       <= 1'b0;
			tog_vld_q   <= 1'b0;
			cyc_start_q <= 1'b0;
			cyc_read_q  <= 1'b0;
			cyc_addr_q  <= '0;
			cyc_data_q  <= 8'h00;
			busy_o      <= 1'b0;
			done_o      <= 1'b0;
			timeout_o   <= 1'b0;
			rdata_o     <= 8'h00;
			wready_o    <= 1'b0;
		end else begin
			cyc_start_q <= 1'b0;
			done_o      <= 1'b0;
			wready_o    <= 1'b0;
			if (st_q == EPW_ST_NEXT || st_q == EPW_ST_DATA) gap_q <= gap_q + 32'd1;
			if (st_q == EPW_ST_POLL) wc_q <= wc_q + 32'd1;
			case (st_q)
				EPW_ST_IDLE: begin
					if (req_i) begin
						op_q      <= op_i;
						base_q    <= addr_i;
						left_q    <= page_cnt;
						offs_q    <= {1'b0, addr_i[`EPW_PAGE_LSB-1:0]};
						cmd_idx_q <= 3'd0;
						busy_o    <= 1'b1;
						timeout_o <= 1'b0;
						if (op_i == EPW_OP_READ) begin
							cyc_start_q <= 1'b1;
							cyc_read_q  <= 1'b1;
							cyc_addr_q  <= addr_i;
							st_q        <= EPW_ST_READ;
						end else if (op_i == EPW_OP_PLAIN) begin
							gap_q <= 32'd0;
							st_q  <= EPW_ST_NEXT;
						end else begin
							st_q <= EPW_ST_CMD;
						end
					end
				end
				EPW_ST_CMD: begin
					// Command bytes follow each other well inside the window
					cyc_start_q <= 1'b1;
					cyc_read_q  <= 1'b0;
					cyc_addr_q  <= cmd_addr;
					cyc_data_q  <= cmd_byte;
					cmd_idx_q   <= cmd_idx_q + 3'd1;
					st_q        <= EPW_ST_DATA;
				end
				EPW_ST_NEXT: begin
					if (take_byte) begin
						wready_o    <= 1'b1;
						cyc_start_q <= 1'b1;
						cyc_read_q  <= 1'b0;
						cyc_addr_q  <= data_addr;
						cyc_data_q  <= wdata_i;
						offs_q      <= offs_q + 8'h01;
						left_q      <= left_q - 8'h01;
						st_q        <= EPW_ST_DATA;
					end else if (gap_late) begin
						// Source too slow: page closes early, device starts writing
						wc_q      <= 32'd0;
						tog_vld_q <= 1'b0;
						st_q      <= EPW_ST_POLL;
					end
				end
				EPW_ST_DATA: begin
					if (cyc_done) begin
						gap_q <= 32'd0;
						if (cmd_idx_q != 3'd0 && cmd_idx_q < cmd_len) begin
							st_q <= EPW_ST_CMD;
						end else if (left_q != 8'h00) begin
							cmd_idx_q <= 3'd0;
							st_q      <= EPW_ST_NEXT;
						end else begin
							cmd_idx_q <= 3'd0;
							wc_q      <= 32'd0;
							tog_vld_q <= 1'b0;
							st_q      <= EPW_ST_POLL;
						end
					end
				end
				EPW_ST_POLL: begin
					if (!cyc_start_q && cyc_done) begin
						tog_q     <= tog_now;
						tog_vld_q <= 1'b1;
						if (tog_same) begin
							st_q <= EPW_ST_DONE;
						end else if (wc_over) begin
							timeout_o <= 1'b1;
							st_q      <= EPW_ST_DONE;
						end else begin
							cyc_start_q <= 1'b1;
						end
					end else if (!tog_vld_q && !cyc_start_q && wc_q == 32'd0) begin
						// Same address for every poll read
						cyc_start_q <= 1'b1;
						cyc_read_q  <= 1'b1;
						cyc_addr_q  <= base_q;
					end
				end
				EPW_ST_READ: begin
					if (cyc_done) begin
						rdata_o <= cyc_rdata;
						st_q    <= EPW_ST_DONE;
					end
				end
				EPW_ST_DONE: begin
					busy_o <= 1'b0;
					done_o <= 1'b1;
					st_q   <= EPW_ST_IDLE;
				end
				default: st_q <= EPW_ST_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Pin cycle engine
	// ---------------------------------------------------------------
	epw_strobe u_strobe (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.start_i   (cyc_start_q),
		.is_read_i (cyc_read_q),
		.addr_i    (cyc_addr_q),
		.wdata_i   (cyc_data_q),
		.done_o    (cyc_done),
		.rdata_o   (cyc_rdata),
		.ce_n_o    (ce_n_o),
		.oe_n_o    (oe_n_o),
		.we_n_o    (we_n_o),
		.addr_o    (addr_o),
		.dq_o      (dq_o),
		.dq_oe_o   (dq_oe_o),
		.dq_i      (dq_i)
	);

endmodule

`default_nettype wire

// ==== sim/epw_host_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module epw_host_sva
	import epw_pkg::*;
(
	input wire logic        ref_clk_i,
	input wire logic        rst_n_i,
	input wire logic        req_i,
	input wire epw_op_e     op_i,
	input wire logic [18:0] addr_i,
	input wire logic        busy_o,
	input wire logic        done_o,
	input wire logic        ce_n_o,
	input wire logic        oe_n_o,
	input wire logic        we_n_o,
	input wire logic [18:0] addr_o,
	input wire logic [7:0]  dq_o,
	input wire logic        dq_oe_o
);
	// ----------
	// Checks
	// ----------
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	epw_op_e     op_q;
	logic [18:0] a_q;
	logic        first_q;
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			op_q <= EPW_OP_PLAIN;
			a_q <= 19'h00000;
			first_q <= 1'b0;
		end else if (req_i && !busy_o) begin
			op_q <= op_i;
			a_q <= addr_i;
			first_q <= 1'b1;
		end else if (!we_n_o) begin
			first_q <= 1'b0;
		end
	end
	sequence s_wlow;
		(!we_n_o)[*8] ##1 (!we_n_o)[*2];
	endsequence
	property p_rd; !oe_n_o |-> we_n_o && !dq_oe_o; endproperty
	property p_wr; !we_n_o |-> !ce_n_o && oe_n_o && dq_oe_o; endproperty
	property p_wpulse; $fell(we_n_o) |-> s_wlow; endproperty
	property p_bank; !ce_n_o && !$past(ce_n_o) |-> $stable(addr_o[18:17]); endproperty
	property p_page;
		$fell(we_n_o) && op_q == EPW_OP_PLAIN |-> addr_o[18:7] == a_q[18:7];
	endproperty
	property p_cmd;
		$fell(we_n_o) && first_q && op_q != EPW_OP_PLAIN |-> addr_o[14:0] == 15'h5555
			&& dq_o == 8'hAA && addr_o[18:17] == a_q[18:17];
	endproperty
	property p_poll; $fell(oe_n_o) && op_q != EPW_OP_READ |-> addr_o == a_q; endproperty
	property p_idle; !busy_o && !done_o && !req_i |-> ce_n_o && we_n_o; endproperty
	a_rd: assert property (p_rd) else $error("read strobe overlaps write");
	a_wr: assert property (p_wr) else $error("write strobe mode wrong");
	a_wpulse: assert property (p_wpulse) else $error("write pulse too short");
	a_bank: assert property (p_bank) else $error("bank lines moved");
	a_page: assert property (p_page) else $error("page bits moved");
	a_cmd: assert property (p_cmd) else $error("first command byte wrong");
	a_poll: assert property (p_poll) else $error("poll address moved");
	a_idle: assert property (p_idle) else $error("strobe while idle");
endmodule
bind epw_host epw_host_sva epw_host_sva_i (
	.ref_clk_i (ref_clk_i),
	.rst_n_i   (rst_n_i),
	.req_i     (req_i),
	.op_i      (op_i),
	.addr_i    (addr_i),
	.busy_o    (busy_o),
	.done_o    (done_o),
	.ce_n_o    (ce_n_o),
	.oe_n_o    (oe_n_o),
	.we_n_o    (we_n_o),
	.addr_o    (addr_o),
	.dq_o      (dq_o),
	.dq_oe_o   (dq_oe_o)
);
`default_nettype wire

// ==== sim/epw_dev_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module epw_dev_model #(
	parameter int BLC_CYC = 300,
	parameter int WR_CYC  = 150
) (
	input  wire logic        clk_i,
	input  wire logic        ce_n_i,
	input  wire logic        oe_n_i,
	input  wire logic        we_n_i,
	input  wire logic [18:0] addr_i,
	input  wire logic [7:0]  dq_i,
	output logic [7:0]       dq_o
);
	// ----------
	// Device
	// ----------
	logic [26:0] ld_q[$];
	logic [26:0] pend[$];
	logic [26:0] lat;
	logic [7:0]  mem[logic [18:0]];
	logic        wr_q = 1'b0;
	logic        rd_q = 1'b0;
	logic        tog = 1'b0;
	bit          prot, setp, clrp;
	int          idle, busy;
	wire         wr = !ce_n_i && !we_n_i && oe_n_i;
	wire         rd = !ce_n_i && !oe_n_i && we_n_i;
	initial dq_o = 8'h00;
	function automatic bit cm(int n, logic [14:0] a, logic [7:0] d);
		return ld_q.size() > n && ld_q[n][22:0] == {a, d};
	endfunction
	task automatic commit();
		int s;
		setp = cm(0, 15'h5555, 8'hAA) && cm(1, 15'h2AAA, 8'h55) && cm(2, 15'h5555, 8'hA0);
		clrp = cm(0, 15'h5555, 8'hAA) && cm(1, 15'h2AAA, 8'h55) && cm(2, 15'h5555, 8'h80)
			&& cm(3, 15'h5555, 8'hAA) && cm(4, 15'h2AAA, 8'h55) && cm(5, 15'h5555, 8'h20);
		s = setp ? 3 : clrp ? 6 : 0;
		pend = {};
		if (!prot || s > 0)
			for (int i = s; i < ld_q.size(); i++)
				pend.push_back(ld_q[i]);
		ld_q = {};
		busy = WR_CYC;
	endtask
	always @(posedge clk_i) begin
		wr_q <= wr;
		rd_q <= rd;
		if (wr)
			lat <= {addr_i, dq_i};
		if (wr_q && !wr) begin
			ld_q.push_back(lat);
			idle = 0;
		end else if (ld_q.size() > 0 && (idle >= BLC_CYC || (rd && !rd_q)))
			commit();
		else
			idle++;
		if (busy > 0) begin
			busy--;
			if (busy == 0) begin
				foreach (pend[i])
					mem[pend[i][26:8]] = pend[i][7:0];
				prot = setp || (prot && !clrp);
			end
		end
		if (rd && !rd_q && busy > 0)
			tog <= !tog;
		// Released bus shows inverse, not a stale copy
		dq_o <= !rd ? ~dq_o : busy > 0 ? {1'b0, tog, 6'h00}
			: mem.exists(addr_i) ? mem[addr_i] : 8'hFF;
	end
endmodule
`default_nettype wire

// ==== sim/epw_host_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module epw_host_tb;
	import epw_pkg::*;
	// ----------
	// Bench
	// ----------
	logic        ref_clk_i, rst_n_i, req_i, wvalid_i, busy_o, done_o, timeout_o;
	logic        wready_o, ce_n_o, oe_n_o, we_n_o, dq_oe_o, prot;
	epw_op_e     op_i;
	logic [18:0] addr_i, addr_o, p, q;
	logic [7:0]  count_i, wdata_i, rdata_o, dq_o, mdl_q;
	logic [7:0]  exp_mem[logic [18:0]];
	logic [31:0] rng = 32'h000086D9;
	int          err_count, tests_run, n;
	wire logic [7:0] dq_i = dq_oe_o ? dq_o : mdl_q;
	epw_host #(.BLC_SAFE_CYC(200), .WC_CYC(500)) epw_host_i (
		.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .req_i(req_i), .op_i(op_i),
		.addr_i(addr_i), .count_i(count_i), .busy_o(busy_o), .done_o(done_o),
		.timeout_o(timeout_o), .rdata_o(rdata_o), .wvalid_i(wvalid_i), .wdata_i(wdata_i),
		.wready_o(wready_o), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o),
		.addr_o(addr_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .dq_i(dq_i));
	epw_dev_model epw_dev_model_i (.clk_i(ref_clk_i), .ce_n_i(ce_n_o), .oe_n_i(oe_n_o),
		.we_n_i(we_n_o), .addr_i(addr_o), .dq_i(dq_i), .dq_o(mdl_q));
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	function automatic logic [7:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng[7:0];
	endfunction
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wait_done();
		int k;
		for (k = 0; k < 20000 && done_o !== 1'b1; k++)
			@(negedge ref_clk_i);
		if (done_o !== 1'b1) begin
			err_count++;
			report_and_stop();
		end else begin
			chk("timeout", {7'h00, timeout_o}, 8'h00);
			chk("busy", {7'h00, busy_o}, 8'h00);
		end
		@(negedge ref_clk_i);
	endtask
	task automatic op(epw_op_e o, logic [18:0] a, logic [7:0] c, int nb);
		int k;
		req_i = 1'b1;
		op_i = o;
		addr_i = a;
		count_i = c;
		@(negedge ref_clk_i);
		req_i = 1'b0;
		for (int i = 0; i < nb; i++) begin
			wvalid_i = 1'b1;
			wdata_i = rnd();
			for (k = 0; k < 1000 && wready_o !== 1'b1; k++)
				@(negedge ref_clk_i);
			if (wready_o !== 1'b1) begin
				err_count++;
				report_and_stop();
			end else if (o != EPW_OP_PLAIN || !prot)
				exp_mem[{a[18:7], a[6:0] + 7'(i)}] = wdata_i;
			@(negedge ref_clk_i);
		end
		wvalid_i = 1'b0;
		if (o == EPW_OP_PROT_ON)
			prot = 1'b1;
		if (o == EPW_OP_PROT_OFF)
			prot = 1'b0;
		wait_done();
	endtask
	task automatic rd(logic [18:0] a);
		op(EPW_OP_READ, a, 8'h01, 0);
		chk("rdata", rdata_o, exp_mem.exists(a) ? exp_mem[a] : 8'hFF);
	endtask
	task automatic tdone();
		n++;
		$display("test %0d done", n);
	endtask
	initial begin
		{req_i, wvalid_i, rst_n_i, prot} = 4'h0;
		op_i = EPW_OP_PLAIN;
		addr_i = 19'h00000;
		count_i = 8'h00;
		wdata_i = 8'h00;
		repeat (8) @(negedge ref_clk_i);
		rst_n_i = 1'b1;
		@(negedge ref_clk_i);
		p = {rnd(), rnd(), 3'h0};
		q = p ^ 19'h00080;
		op(EPW_OP_PLAIN, p, 8'h03, 3);
		for (int i = 0; i < 3; i++)
			rd(p + 19'(i));
		tdone();
		op(EPW_OP_PLAIN, q, 8'h04, 2);
		rd(q + 19'h00001);
		rd(q + 19'h00002);
		tdone();
		op(EPW_OP_PROT_ON, q + 19'h00004, 8'h01, 1);
		rd(q + 19'h00004);
		op(EPW_OP_PLAIN, p, 8'h02, 2);
		rd(p);
		rd(p + 19'h00001);
		tdone();
		op(EPW_OP_PROT_OFF, q + 19'h00005, 8'h01, 1);
		rd(q + 19'h00005);
		op(EPW_OP_PLAIN, p, 8'h01, 1);
		rd(p);
		tdone();
		op(EPW_OP_PLAIN, {q[18:7], 7'h70}, 8'h00, 128);
		rd({q[18:7], 7'h70});
		rd({q[18:7], 7'h00});
		rd({q[18:7], 7'h6F});
		tdone();
		report_and_stop();
	end
endmodule
`default_nettype wire
